/* rtl/sleep_power_control.sv */
// top: sleep and power control register with analog power switches,
// oscillator gating and sleep/hibernate state
// assumes: 40 mhz core clock; wake sources arrive as pins
//
// Overview of operation
// - bit 7 set enables hibernate; clear keeps normal operating mode
// - bit 6 unimplemented: writes ignored, reads zero
// - bit 5 set turns off bandgap, low voltage detector, bias generator
// - bit 4 set powers down level shift; inputs keep working
// - bit 4 clear powers level shift network, half-volt input offset
// - bit 3 set stops main oscillator in sleep; clear keeps it running
// - bit 2 set powers off programmable reference and comparators
// - bit 1 set powers off temperature sensor
// - bit 0 set powers off converter comparator, current source, divider
// - sleep command with hibernate select set enters hibernate
// - oscillator-off bit acts only in sleep; otherwise oscillator runs
// - hibernate wakes on every sleep wake source except watchdog
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps
`default_nettype none
module sleep_power_control
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic ce_in,
   input wire logic [11:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [11:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic wake_event_in,
   input wire logic watchdog_timeout_in,
   output logic hibernate_select_out,
   output logic references_off_out,
   output logic level_shift_off_out,
   output logic comparator_reference_off_out,
   output logic temperature_sensor_off_out,
   output logic converter_power_off_out,
   output logic main_oscillator_run_out,
   output logic cpu_clock_run_out,
   output logic watchdog_run_out,
   output logic asleep_out,
   output logic hibernating_out
);
   logic rst_meta_reg;
   logic rst_sync_reg;
   logic wake_meta_reg;
   logic wake_sync_reg;
   logic wdt_meta_reg;
   logic wdt_sync_reg;
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   sleep_power_pkg::power_state_t state_reg;
   sleep_power_pkg::power_state_t state_next;
   wire logic rst_n;
   wire logic in_sleep;
   wire logic in_hib;
   wire logic wake_now;

   reg_access_if regs ();

   // ---------------------------------------------------------------
   // reset and input synchronisers
   // ---------------------------------------------------------------
   // reset released through two flops
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign rst_n = rst_sync_reg;

   // wake pins pass two flops before use
   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wake_meta_reg <= 1'b0;
         wake_sync_reg <= 1'b0;
         wdt_meta_reg <= 1'b0;
         wdt_sync_reg <= 1'b0;
      end
      else if (ce_in)
      begin
         wake_meta_reg <= wake_event_in;
         wake_sync_reg <= wake_meta_reg;
         wdt_meta_reg <= watchdog_timeout_in;
         wdt_sync_reg <= wdt_meta_reg;
      end
   end

   // ---------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------
   axi_reg_slave u_slave
   (
      .clk_in(clk_in),
      .ce_in(ce_in),
      .rst_n(rst_n),
      .awaddr_in(s_axi_awaddr_in),
      .awvalid_in(s_axi_awvalid_in),
      .awready_out(s_axi_awready_out),
      .wdata_in(s_axi_wdata_in),
      .wstrb_in(s_axi_wstrb_in),
      .wvalid_in(s_axi_wvalid_in),
      .wready_out(s_axi_wready_out),
      .bresp_out(s_axi_bresp_out),
      .bvalid_out(s_axi_bvalid_out),
      .bready_in(s_axi_bready_in),
      .araddr_in(s_axi_araddr_in),
      .arvalid_in(s_axi_arvalid_in),
      .arready_out(s_axi_arready_out),
      .rdata_out(s_axi_rdata_out),
      .rresp_out(s_axi_rresp_out),
      .rvalid_out(s_axi_rvalid_out),
      .rready_in(s_axi_rready_in),
      .regs(regs)
   );

   // ---------------------------------------------------------------
   // control register
   // ---------------------------------------------------------------
   // bit 6 masked off on write so it always reads zero
   assign ctrl_next = regs.wr_ctrl
      ? (regs.wdata & sleep_power_pkg::SLEEP_POWER_CONTROL_MASK)
      : ctrl_reg;

   // control register, power-on value
   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_reg <= sleep_power_pkg::SLEEP_POWER_CONTROL_RESET;
      else if (ce_in)
         ctrl_reg <= ctrl_next;
   end
   assign regs.ctrl_q = ctrl_reg;
   assign regs.state_q = {in_hib, in_sleep};

   // ---------------------------------------------------------------
   // sleep / hibernate state
   // ---------------------------------------------------------------
   // watchdog wakes plain sleep only
   assign wake_now = (state_reg == sleep_power_pkg::ST_SLEEP)
      ? (wake_sync_reg || wdt_sync_reg)
      : wake_sync_reg;

   // next power state
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         sleep_power_pkg::ST_RUN:
            if (regs.wr_cmd && regs.wdata[sleep_power_pkg::CMD_SLEEP])
               state_next = ctrl_next[sleep_power_pkg::BIT_HIBERNATE_SELECT]
                  ? sleep_power_pkg::ST_HIBERNATE
                  : sleep_power_pkg::ST_SLEEP;
         sleep_power_pkg::ST_SLEEP:
            if (wake_now)
               state_next = sleep_power_pkg::ST_RUN;
         sleep_power_pkg::ST_HIBERNATE:
            if (wake_now)
               state_next = sleep_power_pkg::ST_RUN;
         default:
            state_next = sleep_power_pkg::ST_RUN;
      endcase
   end

   // state register
   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
         state_reg <= sleep_power_pkg::ST_RUN;
      else if (ce_in)
         state_reg <= state_next;
   end

   assign in_sleep = state_reg != sleep_power_pkg::ST_RUN;
   assign in_hib = state_reg == sleep_power_pkg::ST_HIBERNATE;

   // ---------------------------------------------------------------
   // power and clock outputs, from the control and state registers
   // ---------------------------------------------------------------
   // each switch follows its bit with no extra stage
   assign hibernate_select_out =
      ctrl_reg[sleep_power_pkg::BIT_HIBERNATE_SELECT];
   assign references_off_out =
      ctrl_reg[sleep_power_pkg::BIT_REFERENCES_OFF];
   assign level_shift_off_out =
      ctrl_reg[sleep_power_pkg::BIT_LEVEL_SHIFT_OFF];
   assign comparator_reference_off_out =
      ctrl_reg[sleep_power_pkg::BIT_COMPARATOR_REFERENCE_OFF];
   assign temperature_sensor_off_out =
      ctrl_reg[sleep_power_pkg::BIT_TEMPERATURE_SENSOR_OFF];
   assign converter_power_off_out =
      ctrl_reg[sleep_power_pkg::BIT_CONVERTER_POWER_OFF];

   // oscillator stops only in sleep with its bit set
   assign main_oscillator_run_out = !in_sleep
      || !ctrl_reg[sleep_power_pkg::BIT_OSCILLATOR_OFF_IN_SLEEP];
   assign cpu_clock_run_out = !in_sleep;
   assign watchdog_run_out = !in_hib;
   assign asleep_out = in_sleep;
   assign hibernating_out = in_hib;
endmodule // sleep_power_control
`default_nettype wire

/* rtl/sleep_power_pkg.sv */
// package: register map, field positions and reset values of the
// sleep and power control block
// assumes: nothing beyond a systemverilog compiler
`default_nettype none
package sleep_power_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   // printed offset is odd, so it is an index; byte address is 4x
   localparam logic [7:0] SLEEP_POWER_CONTROL_INDEX = 8'h8f;
   localparam logic [11:0] SLEEP_POWER_CONTROL_ADDR = 12'h23c;
   localparam logic [7:0] SLEEP_STATUS_INDEX = 8'h90;
   localparam logic [11:0] SLEEP_STATUS_ADDR = 12'h240;
   localparam logic [11:0] SLEEP_COMMAND_ADDR = 12'h244;
   localparam int ADDR_WIDTH = 12;
   localparam int REG_WIDTH = 8;
   localparam logic [7:0] SLEEP_POWER_CONTROL_RESET = 8'h3f;
   localparam logic [7:0] SLEEP_POWER_CONTROL_MASK = 8'hbf;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int BIT_HIBERNATE_SELECT = 7;
   localparam int BIT_REFERENCES_OFF = 5;
   localparam int BIT_LEVEL_SHIFT_OFF = 4;
   localparam int BIT_OSCILLATOR_OFF_IN_SLEEP = 3;
   localparam int BIT_COMPARATOR_REFERENCE_OFF = 2;
   localparam int BIT_TEMPERATURE_SENSOR_OFF = 1;
   localparam int BIT_CONVERTER_POWER_OFF = 0;
   // status register bits
   localparam int STAT_ASLEEP = 0;
   localparam int STAT_HIBERNATING = 1;
   // command register bit
   localparam int CMD_SLEEP = 0;
   // ----------------------------------------------------------------
   // axi responses
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------------------------------
   // power state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_SLEEP = 2'b01,
      ST_HIBERNATE = 2'b10
   } power_state_t;
endpackage
`default_nettype wire

/* rtl/reg_access_if.sv */
// interface: register write strobes and read-back values between bus slave and core
// assumes: both ends on the same clock
`timescale 1ns/10ps
`default_nettype none
interface reg_access_if;
   logic wr_ctrl;
   logic wr_cmd;
   logic [7:0] wdata;
   logic [7:0] ctrl_q;
   logic [1:0] state_q;
   modport slave (output wr_ctrl, output wr_cmd, output wdata,
                  input ctrl_q, input state_q);
   modport core (input wr_ctrl, input wr_cmd, input wdata,
                 output ctrl_q, output state_q);
endinterface
`default_nettype wire

/* rtl/axi_reg_slave.sv */
// axi4-lite slave: decodes the three registers; control and command writes become strobes
// assumes: clock, enable and synchronised reset from the top module
`timescale 1ns/10ps
`default_nettype none
module axi_reg_slave
(
   input wire logic clk_in,
   input wire logic ce_in,
   input wire logic rst_n,
   input wire logic [11:0] awaddr_in,
   input wire logic awvalid_in,
   output logic awready_out,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] wstrb_in,
   input wire logic wvalid_in,
   output logic wready_out,
   output logic [1:0] bresp_out,
   output logic bvalid_out,
   input wire logic bready_in,
   input wire logic [11:0] araddr_in,
   input wire logic arvalid_in,
   output logic arready_out,
   output logic [31:0] rdata_out,
   output logic [1:0] rresp_out,
   output logic rvalid_out,
   input wire logic rready_in,
   reg_access_if.slave regs
);
   logic aw_held_reg;
   logic w_held_reg;
   logic [11:0] awaddr_reg;
   logic [7:0] wdata_reg;
   logic wlane_reg;
   logic [1:0] bresp_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic bvalid_reg;
   logic rvalid_reg;
   wire logic aw_take;
   wire logic w_take;
   wire logic do_write;
   wire logic ar_take;
   wire logic wr_known;
   wire logic rd_ctrl;
   wire logic rd_stat;
   wire logic rd_known;

   // ---------------------------------------------------------------
   // handshakes and decode
   // ---------------------------------------------------------------
   assign awready_out = ce_in && !aw_held_reg && !bvalid_reg;
   assign wready_out = ce_in && !w_held_reg && !bvalid_reg;
   assign aw_take = awvalid_in && awready_out;
   assign w_take = wvalid_in && wready_out;
   assign do_write = ce_in && aw_held_reg && w_held_reg && !bvalid_reg;
   assign wr_known = awaddr_reg == sleep_power_pkg::SLEEP_POWER_CONTROL_ADDR
      || awaddr_reg == sleep_power_pkg::SLEEP_COMMAND_ADDR;
   assign regs.wr_ctrl = do_write && wlane_reg
      && awaddr_reg == sleep_power_pkg::SLEEP_POWER_CONTROL_ADDR;
   assign regs.wr_cmd = do_write && wlane_reg
      && awaddr_reg == sleep_power_pkg::SLEEP_COMMAND_ADDR;
   assign regs.wdata = wdata_reg;
   assign arready_out = ce_in && !rvalid_reg;
   assign ar_take = arvalid_in && arready_out;
   assign rd_ctrl = araddr_in == sleep_power_pkg::SLEEP_POWER_CONTROL_ADDR;
   assign rd_stat = araddr_in == sleep_power_pkg::SLEEP_STATUS_ADDR;
   assign rd_known = rd_ctrl || rd_stat
      || araddr_in == sleep_power_pkg::SLEEP_COMMAND_ADDR;
   assign bresp_out = bresp_reg;
   assign bvalid_out = bvalid_reg;
   assign rdata_out = rdata_reg;
   assign rresp_out = rresp_reg;
   assign rvalid_out = rvalid_reg;

   // write channel capture and response
   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 12'h000;
         wdata_reg <= 8'h00;
         wlane_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'h0;
      end
      else if (ce_in)
      begin
         if (aw_take)
         begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= awaddr_in;
         end
         if (w_take)
         begin
            w_held_reg <= 1'b1;
            wdata_reg <= wdata_in[7:0];
            wlane_reg <= wstrb_in[0];
         end
         if (do_write)
         begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_known ? sleep_power_pkg::RESP_OKAY
                                  : sleep_power_pkg::RESP_SLVERR;
         end
         else if (bvalid_reg && bready_in)
            bvalid_reg <= 1'b0;
      end
   end

   // read channel: one beat, upper bits zero
   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= 2'h0;
      end
      else if (ce_in)
      begin
         if (ar_take)
         begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_ctrl ? {24'h000000, regs.ctrl_q}
               : rd_stat ? {30'h00000000, regs.state_q} : 32'h00000000;
            rresp_reg <= rd_known ? sleep_power_pkg::RESP_OKAY
                                  : sleep_power_pkg::RESP_SLVERR;
         end
         else if (rvalid_reg && rready_in)
            rvalid_reg <= 1'b0;
      end
   end
endmodule // axi_reg_slave
`default_nettype wire

/* testbench/sleep_power_assertions.sv */
// checker: port assertions of the sleep and power control block
// assumes: bound onto the top module, single clock domain
`timescale 1ns/10ps
`default_nettype none
module sleep_power_assertions
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic ce_in,
   input wire logic s_axi_awvalid_in,
   input wire logic s_axi_awready_out,
   input wire logic s_axi_wvalid_in,
   input wire logic s_axi_wready_out,
   input wire logic s_axi_bvalid_out,
   input wire logic s_axi_arready_out,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic s_axi_rvalid_out,
   input wire logic wake_event_in,
   input wire logic hibernate_select_out,
   input wire logic references_off_out,
   input wire logic level_shift_off_out,
   input wire logic comparator_reference_off_out,
   input wire logic temperature_sensor_off_out,
   input wire logic converter_power_off_out,
   input wire logic main_oscillator_run_out,
   input wire logic watchdog_run_out,
   input wire logic asleep_out,
   input wire logic hibernating_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!arst_n_in);
   // all power switch levels as one word
   wire logic [5:0] pwr = {hibernate_select_out, references_off_out,
      level_shift_off_out, comparator_reference_off_out,
      temperature_sensor_off_out, converter_power_off_out};
   sequence both_taken;
      s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
         && s_axi_wready_out;
   endsequence
   sequence no_wake;
      !wake_event_in [*4];
   endsequence
   a_write_answer: assert property (both_taken |-> ##2 s_axi_bvalid_out)
      else $error("write response not two cycles after take");
   a_power_on_write: assert property (!$rose(s_axi_bvalid_out) |-> $stable(pwr))
      else $error("power switch moved without a write");
   a_osc_awake: assert property (!asleep_out |-> main_oscillator_run_out)
      else $error("oscillator stopped while awake");
   a_hib_enter: assert property ($rose(hibernating_out) |-> hibernate_select_out && asleep_out)
      else $error("hibernate entered without select");
   a_hib_wdt_off: assert property (hibernating_out |-> !watchdog_run_out)
      else $error("watchdog running in hibernate");
   a_hib_keeps: assert property (no_wake ##0 hibernating_out |=> hibernating_out)
      else $error("hibernate left without wake event");
   a_wake_ends: assert property (asleep_out && wake_event_in |-> ##[1:4] !asleep_out)
      else $error("wake event did not end sleep");
   a_bit6_zero: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0 && !s_axi_rdata_out[6])
      else $error("unimplemented read bits not zero");
   a_ready_ce: assert property (!ce_in |-> !(s_axi_awready_out || s_axi_wready_out || s_axi_arready_out))
      else $error("ready high while clock enable low");
endmodule // sleep_power_assertions
bind sleep_power_control sleep_power_assertions chk (.*);
`default_nettype wire

/* testbench/wake_source_model.sv */
// partner: wake and watchdog sources, analog switch states
// assumes: block clock, requests from the bench
`timescale 1ns/10ps
`default_nettype none
module wake_source_model
(
   input wire logic clk_in,
   input wire logic wake_req_in,
   input wire logic wdt_req_in,
   input wire logic [5:0] power_off_in,
   output logic wake_event_out,
   output logic watchdog_timeout_out,
   output logic [5:0] powered_out
);
   // source levels change just after the edge
   always_ff @(posedge clk_in)
   begin
      wake_event_out <= wake_req_in;
      watchdog_timeout_out <= wdt_req_in;
   end
   // a module is powered while its off level is low
   assign powered_out = ~power_off_in;
endmodule // wake_source_model
`default_nettype wire

/* testbench/sleep_power_control_tb.sv */
// testbench: register rows, reset, sleep, hibernate, bus errors
// assumes: package, design, partner and checker compiled first
`timescale 1ns/10ps
`default_nettype none
module sleep_power_control_tb;
   localparam logic [11:0] CTRL = sleep_power_pkg::SLEEP_POWER_CONTROL_ADDR;
   localparam logic [11:0] STAT = sleep_power_pkg::SLEEP_STATUS_ADDR;
   localparam logic [11:0] CMD = sleep_power_pkg::SLEEP_COMMAND_ADDR;
   logic clk_in = 1'b0, arst_n_in = 1'b0, ce_in = 1'b1;
   logic [11:0] s_axi_awaddr_in = 12'h0, s_axi_araddr_in = 12'h0;
   logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, rd;
   logic [3:0] s_axi_wstrb_in = 4'h0;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rsp;
   logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
   logic s_axi_bready_in = 1'b0, s_axi_arvalid_in = 1'b0;
   logic s_axi_rready_in = 1'b0, wake_req = 1'b0, wdt_req = 1'b0;
   logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
   logic s_axi_arready_out, s_axi_rvalid_out, wake_event_in;
   logic watchdog_timeout_in, hibernate_select_out, references_off_out;
   logic level_shift_off_out, comparator_reference_off_out;
   logic temperature_sensor_off_out, converter_power_off_out;
   logic main_oscillator_run_out, cpu_clock_run_out, watchdog_run_out;
   logic asleep_out, hibernating_out;
   logic [5:0] powered;
   int n_mismatch = 0, compares = 0, k;
   // rows: written value, value read back
   logic [15:0] rows [6] = '{16'hffbf, 16'h0000, 16'h5515, 16'haaaa,
      16'h4000, 16'h7f3f};
   // sleep state: asleep, hibernating, osc, cpu, watchdog
   wire logic [4:0] st = {asleep_out, hibernating_out,
      main_oscillator_run_out, cpu_clock_run_out, watchdog_run_out};
   always #12.5 clk_in = ~clk_in;
   sleep_power_control DUT (.*);
   wake_source_model partner (.clk_in(clk_in), .wake_req_in(wake_req),
      .wdt_req_in(wdt_req), .power_off_in({hibernate_select_out,
      references_off_out, level_shift_off_out,
      comparator_reference_off_out, temperature_sensor_off_out,
      converter_power_off_out}), .wake_event_out(wake_event_in),
      .watchdog_timeout_out(watchdog_timeout_in), .powered_out(powered));
   // expected powered switches for a control value
   function automatic logic [5:0] sw(input logic [7:0] v);
      return ~{v[7], v[5], v[4], v[2], v[1], v[0]};
   endfunction
   task automatic test_done();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] s);
      compares++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic hang();
      n_mismatch++;
      $display("[FAIL] handshake expected answer seen none");
      test_done();
   endtask
   // axi write, both channels offered together
   task automatic wr(input logic [11:0] a, input logic [7:0] d,
      input logic [3:0] s);
      int i;
      @(posedge clk_in);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= {24'h0, d};
      s_axi_wstrb_in <= s;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      s_axi_bready_in <= 1'b1;
      for (i = 0; i < 40; i++)
      begin
         @(posedge clk_in);
         if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
         if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
         if (s_axi_bvalid_out)
         begin
            rsp = s_axi_bresp_out;
            s_axi_bready_in <= 1'b0;
            return;
         end
      end
      hang();
   endtask
   // axi read into rd and rsp
   task automatic rdr(input logic [11:0] a);
      int i;
      @(posedge clk_in);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in <= 1'b1;
      for (i = 0; i < 40; i++)
      begin
         @(posedge clk_in);
         if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
         if (s_axi_rvalid_out)
         begin
            rd = s_axi_rdata_out;
            rsp = s_axi_rresp_out;
            s_axi_rready_in <= 1'b0;
            return;
         end
      end
      hang();
   endtask
   // bounded wait for a sleep level
   task automatic until_sleep(input logic v);
      int i;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk_in);
         if (asleep_out === v) return;
      end
      hang();
   endtask
   // main sequence
   initial
   begin
      repeat (12) @(posedge clk_in);
      arst_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      for (k = 0; k < 6; k++)
      begin
         wr(CTRL, rows[k][15:8], 4'h1);
         chk("write resp", 32'(sleep_power_pkg::RESP_OKAY), 32'(rsp));
         chk("powered", 32'(sw(rows[k][7:0])), 32'(powered));
         rdr(CTRL);
         chk("control", 32'(rows[k][7:0]), rd);
      end
      // mid-run reset back to power-on value
      arst_n_in <= 1'b0;
      @(posedge clk_in);
      chk("reset powered", 32'(sw(8'h3f)), 32'(powered));
      arst_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      rdr(CTRL);
      chk("reset control", 32'h3f, rd);
      // sleep, oscillator off, watchdog wakes
      wr(CTRL, 8'h08, 4'h1);
      wr(CMD, 8'h01, 4'h1);
      chk("sleep osc off", 32'h11, 32'(st));
      rdr(STAT);
      chk("status", 32'h1, rd);
      wdt_req <= 1'b1;
      until_sleep(1'b0);
      chk("woken osc", 32'h1, 32'(main_oscillator_run_out));
      wdt_req <= 1'b0;
      repeat (5) @(posedge clk_in);
      // sleep, oscillator kept running, wake pin
      wr(CTRL, 8'h00, 4'h1);
      wr(CMD, 8'h01, 4'h1);
      chk("sleep osc on", 32'h15, 32'(st));
      wake_req <= 1'b1;
      until_sleep(1'b0);
      chk("awake osc", 32'h1, 32'(main_oscillator_run_out));
      wake_req <= 1'b0;
      repeat (5) @(posedge clk_in);
      // hibernate ignores watchdog, wakes on pin
      wr(CTRL, 8'h80, 4'h1);
      wr(CMD, 8'h01, 4'h1);
      chk("hibernate", 32'h1c, 32'(st));
      wdt_req <= 1'b1;
      repeat (10) @(posedge clk_in);
      chk("hib watchdog", 32'h1, 32'(hibernating_out));
      wdt_req <= 1'b0;
      repeat (5) @(posedge clk_in);
      wake_req <= 1'b1;
      until_sleep(1'b0);
      chk("hib woken", 32'h0, 32'(hibernating_out));
      wake_req <= 1'b0;
      // clock enable low holds the bus off
      ce_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      chk("ce ready", 32'h0, 32'({s_axi_awready_out, s_axi_wready_out,
         s_axi_arready_out}));
      ce_in <= 1'b1;
      // unmapped place and masked write
      wr(12'h400, 8'h12, 4'h1);
      chk("unmapped wr", 32'(sleep_power_pkg::RESP_SLVERR), 32'(rsp));
      rdr(12'h400);
      chk("unmapped rd", 32'h0, rd);
      chk("unmapped rresp", 32'(sleep_power_pkg::RESP_SLVERR), 32'(rsp));
      wr(CTRL, 8'h00, 4'h0);
      rdr(CTRL);
      chk("strobe off", 32'h80, rd);
      test_done();
   end
endmodule // sleep_power_control_tb
`default_nettype wire
